// *** rtl/sas_sequencer.sv ***
// What this block does
// - Software picks supply or external references
// - Converts in sleep only on RC clock
// - One result bit resolved per conversion period after the first
// - Reset clears control, disables, aborts conversion
// - Each pin selectable analog or digital
// - Result pair loaded when conversion ends
// - Completion clears start bit, sets flag
// - Result pair survives reset, undefined at power-up
// - Optional programmed acquisition after start bit
// - Two periods gap before next acquisition
// - Thirteen periods, twelve-bit result per conversion
// - Field zero means manual, immediate conversion
// - Programmed acquisition of 2 to 20 periods
// - Sampling resumes on selected channel afterwards
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module sas_sequencer (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [sas_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Power manager
    input wire logic sleep_i,
    // Analog front end
    input wire logic cmp_i,
    output logic sample_o,
    output logic [sas_pkg::CH_W-1:0] chan_o,
    output logic [sas_pkg::RES_W-1:0] dac_o,
    output logic ref_pos_ext_o,
    output logic ref_neg_ext_o,
    output logic [sas_pkg::PIN_N-1:0] pin_analog_o
);
    import sas_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        sas_state_e st;
        logic en;
        logic go;
        logic [CH_W-1:0] ch;
        logic [PIN_N-1:0] pin;
        logic rpos;
        logic rneg;
        logic [2:0] csel;
        logic [2:0] acqt;
        logic flag;
        logic ien;
        logic global_irq_enable;
        logic [RES_W-1:0] res;
        logic [RES_W-1:0] dac;
        logic [3:0] cnt;
        logic [4:0] acnt;
        logic smp;
        logic c1;
        logic c2;
        logic [31:0] rdata;
        logic rdy;
        logic err;
    } sas_regs_s;

    localparam sas_regs_s RST_S = '{
        st: ST_IDLE,
        en: 1'b0,
        go: 1'b0,
        ch: '0,
        pin: PIN_RST,
        rpos: 1'b0,
        rneg: 1'b0,
        csel: CLKSEL_RST,
        acqt: ACQ_RST,
        flag: 1'b0,
        ien: 1'b0,
        global_irq_enable: 1'b0,
        res: '0,
        dac: '0,
        cnt: 4'h0,
        acnt: 5'h00,
        smp: 1'b0,
        c1: 1'b0,
        c2: 1'b0,
        rdata: 32'h0000_0000,
        rdy: 1'b0,
        err: 1'b0
    };

    sas_regs_s s_q;
    sas_regs_s s_d;

    sas_tad_if tad ();

    sas_tad_gen u_tad (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .tad   (tad)
    );

    logic wr;
    logic setup;
    logic mapped;
    logic done;
    logic tick;
    logic [3:0] bidx;

    assign tick = tad.tick;
    assign setup = psel_i && !penable_i;
    assign wr = psel_i && penable_i && s_q.rdy && pwrite_i;
    assign done = (s_q.st == ST_CONV) && tick && (s_q.cnt == CONV_LAST);
    assign bidx = 4'(CONV_LAST - s_q.cnt);

    // Conversion clock halts in sleep unless it comes from the RC
    assign tad.src = s_q.csel;
    assign tad.run = s_q.en && !(sleep_i && !is_rc(s_q.csel));

    always_comb begin
        case (paddr_i)
            OFF_CTRL0,
            OFF_PINREF,
            OFF_TIMING,
            OFF_RES_HIGH,
            OFF_RES_LOW,
            OFF_IRQ: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // Comparator arrives from the analog side
        s_d.c1 = cmp_i;
        s_d.c2 = s_q.c1;

        // Bus: answer is prepared in the setup cycle
        s_d.rdy = setup;
        s_d.err = setup && !mapped;
        s_d.rdata = 32'h0000_0000;
        if (setup) begin
            case (paddr_i)
                OFF_CTRL0: begin
                    s_d.rdata[CTRL_EN] = s_q.en;
                    s_d.rdata[CTRL_GO] = s_q.go;
                    s_d.rdata[CTRL_CH_LSB +: CH_W] = s_q.ch;
                end
                OFF_PINREF: begin
                    s_d.rdata[PIN_N-1:0] = s_q.pin;
                    s_d.rdata[REF_POS_BIT] = s_q.rpos;
                    s_d.rdata[REF_NEG_BIT] = s_q.rneg;
                end
                OFF_TIMING: begin
                    s_d.rdata[TIM_CLK_LSB +: 3] = s_q.csel;
                    s_d.rdata[TIM_ACQ_LSB +: 3] = s_q.acqt;
                end
                OFF_RES_HIGH: s_d.rdata[3:0] = s_q.res[11:8];
                OFF_RES_LOW: s_d.rdata[7:0] = s_q.res[7:0];
                OFF_IRQ: begin
                    s_d.rdata[IRQ_FLAG_BIT] = s_q.flag;
                    s_d.rdata[IRQ_EN_BIT] = s_q.ien;
                    s_d.rdata[IRQ_GIE_BIT] = s_q.global_irq_enable;
                end
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end

        // Register writes take effect in the access cycle
        if (wr) begin
            case (paddr_i)
                OFF_CTRL0: begin
                    s_d.en = pwdata_i[CTRL_EN];
                    s_d.go = pwdata_i[CTRL_GO] && pwdata_i[CTRL_EN];
                    s_d.ch = pwdata_i[CTRL_CH_LSB +: CH_W];
                end
                OFF_PINREF: begin
                    s_d.pin = pwdata_i[PIN_N-1:0];
                    s_d.rpos = pwdata_i[REF_POS_BIT];
                    s_d.rneg = pwdata_i[REF_NEG_BIT];
                end
                OFF_TIMING: begin
                    s_d.csel = pwdata_i[TIM_CLK_LSB +: 3];
                    s_d.acqt = pwdata_i[TIM_ACQ_LSB +: 3];
                end
                OFF_IRQ: begin
                    s_d.flag = pwdata_i[IRQ_FLAG_BIT];
                    s_d.ien = pwdata_i[IRQ_EN_BIT];
                    s_d.global_irq_enable = pwdata_i[IRQ_GIE_BIT];
                end
                default: s_d.en = s_d.en;
            endcase
        end

        // --------------------------------------------------------
        // Sequencer
        // --------------------------------------------------------
        unique case (s_q.st)
            ST_IDLE: begin
                s_d.smp = s_d.en;
                if (s_d.en && s_d.go) begin
                    if (s_q.acqt == 3'h0) begin
                        // Manual: hold and convert at once
                        s_d.st = ST_CONV;
                        s_d.smp = 1'b0;
                        s_d.cnt = 4'h0;
                    end else begin
                        s_d.st = ST_ACQ;
                        s_d.acnt = 5'h00;
                    end
                end
            end
            ST_ACQ: begin
                s_d.smp = 1'b1;
                if (tick) begin
                    if (s_q.acnt ==
                        5'(acq_tads(s_q.acqt) - 5'h01)) begin
                        s_d.st = ST_CONV;
                        s_d.smp = 1'b0;
                        s_d.cnt = 4'h0;
                    end else begin
                        s_d.acnt = 5'(s_q.acnt + 5'h01);
                    end
                end
            end
            ST_CONV: begin
                s_d.smp = 1'b0;
                if (tick) begin
                    if (s_q.cnt == 4'h0) begin
                        s_d.dac = SAR_MSB;
                    end else begin
                        // Keep trial bit only if sample is at or above it
                        if (!s_q.c2) begin
                            s_d.dac[bidx] = 1'b0;
                        end
                        if (bidx != 4'h0) begin
                            s_d.dac[4'(bidx - 4'h1)] = 1'b1;
                        end
                    end
                    if (s_q.cnt == CONV_LAST) begin
                        s_d.res = s_d.dac;
                        s_d.go = 1'b0;
                        s_d.flag = 1'b1;
                        s_d.st = ST_GAP;
                        s_d.acnt = 5'h00;
                    end else begin
                        s_d.cnt = 4'(s_q.cnt + 4'h1);
                    end
                end
            end
            ST_GAP: begin
                // Hold off sampling so the next one starts clean
                s_d.smp = 1'b0;
                if (tick) begin
                    if (s_q.acnt == GAP_LAST) begin
                        s_d.st = ST_IDLE;
                        s_d.smp = s_d.en;
                    end else begin
                        s_d.acnt = 5'(s_q.acnt + 5'h01);
                    end
                end
            end
        endcase

        // Disabling the module abandons any conversion
        if (!s_d.en) begin
            s_d.st = ST_IDLE;
            s_d.go = 1'b0;
            s_d.smp = 1'b0;
        end

        // Result pair is deliberately left out of reset
        if (rst_i) begin
            s_d = RST_S;
            s_d.res = s_q.res;
        end
    end

    always_ff @(posedge clk_i) begin
        s_q <= s_d;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata_o = s_q.rdata;
    assign pready_o = s_q.rdy;
    assign pslverr_o = s_q.err;
    assign sample_o = s_q.smp;
    assign chan_o = s_q.ch;
    assign dac_o = s_q.dac;
    assign ref_pos_ext_o = s_q.rpos;
    assign ref_neg_ext_o = s_q.rneg;
    assign pin_analog_o = s_q.pin;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking dcb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    ref_select_a: assert property (
        wr && paddr_i == OFF_PINREF |=>
            ref_pos_ext_o == $past(pwdata_i[REF_POS_BIT]) &&
            ref_neg_ext_o == $past(pwdata_i[REF_NEG_BIT]))
        else $error("reference select not applied");

    sleep_halt_a: assert property (
        sleep_i && s_q.en && !is_rc(s_q.csel) ##1
            sleep_i && !is_rc(s_q.csel) |-> !tick)
        else $error("conversion clock runs in sleep");

    sar_bit_a: assert property (
        s_q.st == ST_CONV && tick && s_q.cnt == 4'h1 && s_d.en |=>
            dac_o[11] == $past(s_q.c2) && dac_o[10])
        else $error("successive approximation bit wrong");

    reset_off_a: assert property (
        @(posedge clk_i) disable iff (1'b0)
        rst_i |=> !s_q.en && !s_q.go && s_q.st == ST_IDLE && !sample_o)
        else $error("reset did not stop converter");

    pin_mode_a: assert property (
        wr && paddr_i == OFF_PINREF |=>
            pin_analog_o == $past(pwdata_i[PIN_N-1:0]))
        else $error("pin mode not applied");

    result_load_a: assert property (
        done && s_d.en |=> s_q.res == $past(s_d.dac) &&
            s_q.st == ST_GAP)
        else $error("result not loaded at end");

    done_flag_a: assert property (
        done |=> !s_q.go && s_q.flag)
        else $error("start bit or flag wrong at end");

    result_keep_a: assert property (
        @(posedge clk_i) disable iff (1'b0)
        rst_i |=> $stable(s_q.res))
        else $error("reset changed the result pair");

    manual_go_a: assert property (
        s_q.st == ST_IDLE && s_d.en && s_d.go && s_q.acqt == 3'h0
            |=> s_q.st == ST_CONV && !sample_o)
        else $error("manual start not immediate");

    acq_len_a: assert property (
        s_q.st == ST_ACQ && s_d.st == ST_CONV |->
            tick && s_q.acnt == 5'(acq_tads(s_q.acqt) - 5'h01))
        else $error("acquisition length wrong");

    gap_len_a: assert property (
        s_q.st == ST_GAP && s_d.st == ST_IDLE && s_d.en |->
            tick && s_q.acnt == GAP_LAST)
        else $error("gap before sampling too short");

    conv_len_a: assert property (
        s_q.st == ST_CONV && s_d.st == ST_GAP |->
            s_q.cnt == CONV_LAST && tick)
        else $error("conversion length wrong");

    resample_a: assert property (
        s_q.st == ST_GAP && s_d.st == ST_IDLE && s_d.en |=>
            sample_o)
        else $error("sampling not resumed");

endmodule
`default_nettype wire

// *** shared/sas_pkg.sv ***
package sas_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL0 = 8'h00;
    localparam logic [7:0] OFF_PINREF = 8'h04;
    localparam logic [7:0] OFF_TIMING = 8'h08;
    localparam logic [7:0] OFF_RES_HIGH = 8'h0C;
    localparam logic [7:0] OFF_RES_LOW = 8'h10;
    localparam logic [7:0] OFF_IRQ = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned CTRL_EN = 0;
    localparam int unsigned CTRL_GO = 1;
    localparam int unsigned CTRL_CH_LSB = 2;
    localparam int unsigned REF_POS_BIT = 16;
    localparam int unsigned REF_NEG_BIT = 17;
    localparam int unsigned TIM_CLK_LSB = 0;
    localparam int unsigned TIM_ACQ_LSB = 3;
    localparam int unsigned IRQ_FLAG_BIT = 0;
    localparam int unsigned IRQ_EN_BIT = 1;
    localparam int unsigned IRQ_GIE_BIT = 2;

    // ------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------
    localparam int unsigned RES_W = 12;
    localparam int unsigned PIN_N = 13;
    localparam int unsigned CH_W = 4;
    localparam logic [3:0] CONV_LAST = 4'hC;
    localparam logic [4:0] GAP_LAST = 5'h01;
    localparam logic [2:0] ACQ_RST = 3'h0;
    localparam logic [2:0] CLKSEL_RST = 3'h0;
    localparam logic [PIN_N-1:0] PIN_RST = '0;
    localparam logic [11:0] SAR_MSB = 12'h800;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned RC_TAD_NS = 2500;
    localparam int unsigned RC_DIV_CYC = RC_TAD_NS / CLK_PERIOD_NS;
    localparam logic [8:0] RC_DIV = 9'(RC_DIV_CYC);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACQ,
        ST_CONV,
        ST_GAP
    } sas_state_e;

    function automatic logic [4:0] acq_tads(input logic [2:0] f);
        case (f)
            3'h1: acq_tads = 5'h02;
            3'h2: acq_tads = 5'h04;
            3'h3: acq_tads = 5'h06;
            3'h4: acq_tads = 5'h08;
            3'h5: acq_tads = 5'h0C;
            3'h6: acq_tads = 5'h10;
            3'h7: acq_tads = 5'h14;
            default: acq_tads = 5'h00;
        endcase
    endfunction

    function automatic logic is_rc(input logic [2:0] sel);
        is_rc = (sel[1:0] == 2'h3);
    endfunction

    function automatic logic [8:0] tad_div(input logic [2:0] sel);
        case (sel)
            3'h0: tad_div = 9'h002;
            3'h4: tad_div = 9'h004;
            3'h1: tad_div = 9'h008;
            3'h5: tad_div = 9'h010;
            3'h2: tad_div = 9'h020;
            3'h6: tad_div = 9'h040;
            default: tad_div = RC_DIV;
        endcase
    endfunction

endpackage

// *** shared/sas_tad_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface sas_tad_if;
    logic [2:0] src;
    logic run;
    logic tick;
    modport gen (input src, input run, output tick);
    modport user (output src, output run, input tick);
endinterface
`default_nettype wire

// *** rtl/sas_tad_gen.sv ***
`timescale 1ns/10ps
`default_nettype none
module sas_tad_gen (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Conversion clock request
    sas_tad_if.gen tad
);
    import sas_pkg::*;

    typedef struct packed {
        logic [8:0] cnt;
        logic tick;
    } sas_gen_s;

    sas_gen_s s_q;
    sas_gen_s s_d;

    // Counter restarts whenever the run request drops
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (rst_i || !tad.run) begin
            s_d.cnt = 9'h000;
        end else if (s_q.cnt == 9'(tad_div(tad.src) - 9'h001)) begin
            s_d.cnt = 9'h000;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = 9'(s_q.cnt + 9'h001);
        end
        if (rst_i) begin
            s_d.tick = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        s_q <= s_d;
    end

    assign tad.tick = s_q.tick;

endmodule
`default_nettype wire

// *** verification/sas_afe_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module sas_afe_model (
    // Clock
    input wire logic clk_i,
    // Front end controls from the block
    input wire logic sample_i,
    input wire logic [sas_pkg::CH_W-1:0] chan_i,
    input wire logic [sas_pkg::RES_W-1:0] dac_i,
    // Source level set by the bench
    input wire logic [sas_pkg::RES_W-1:0] level_i,
    // Comparator
    output logic cmp_o
);
    import sas_pkg::*;

    logic [RES_W-1:0] held_q;

    // ------------------------------------------------------------
    // Hold capacitor
    // ------------------------------------------------------------
    // Tracks only while the switch is closed; channel alters the level
    always_ff @(posedge clk_i) begin
        if (sample_i) begin
            held_q <= level_i ^ {chan_i, 8'h00};
        end
    end

    // Raw comparison, no settling help beyond the block's own sync
    assign cmp_o = (held_q >= dac_i);
endmodule
`default_nettype wire

// *** verification/sas_sequencer_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module sas_sequencer_tb_top;
    import sas_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [ADDR_W-1:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0;
    logic sleep_i = 1'b0;
    logic [RES_W-1:0] level = '0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, cmp_i, sample_o, smp_q;
    logic ref_pos_ext_o, ref_neg_ext_o;
    logic [CH_W-1:0] chan_o;
    logic [RES_W-1:0] dac_o;
    logic [PIN_N-1:0] pin_analog_o;
    int n_mismatch = 0;
    int comparisons = 0;
    int cyc = 0;
    int t_acc, t_go, t_fall, t_rise;

    always #4 clk_i = ~clk_i;

    // Edge times of the sample switch, on the same count as t_acc
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        smp_q <= sample_o;
        if (smp_q === 1'b1 && sample_o === 1'b0) t_fall <= cyc;
        if (smp_q === 1'b0 && sample_o === 1'b1) t_rise <= cyc;
    end

    sas_sequencer u_sas_sequencer (
        .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .sleep_i(sleep_i), .cmp_i(cmp_i),
        .sample_o(sample_o), .chan_o(chan_o), .dac_o(dac_o),
        .ref_pos_ext_o(ref_pos_ext_o), .ref_neg_ext_o(ref_neg_ext_o),
        .pin_analog_o(pin_analog_o)
    );

    sas_afe_model u_sas_afe_model (
        .clk_i(clk_i), .sample_i(sample_o), .chan_i(chan_o),
        .dac_i(dac_o), .level_i(level), .cmp_o(cmp_i)
    );

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic guard(input logic ok);
        if (!ok) begin
            n_mismatch++;
            $display("ERROR %0t: wait ran out", $time);
            finish_test();
        end
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic rng(input int v, input int lo, input int hi);
        comparisons++;
        if (v < lo || v > hi) begin
            n_mismatch++;
            $display("ERROR %0t: %0d cycles, not %0d..%0d", $time, v, lo, hi);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic err);
        int n;
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        guard(pready_o === 1'b1);
        q = prdata_o;
        err = pslverr_o;
        t_acc = cyc;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp);
    endtask

    // One full conversion; slp sleeps meanwhile, frz expects a stall
    task automatic run_conv(input logic [3:0] ch, input logic [5:0] tim,
                            input logic [11:0] lv, input logic slp,
                            input logic frz);
        logic [31:0] q;
        logic [31:0] ctl;
        logic [11:0] ex;
        logic e;
        int n;
        ex = lv ^ {ch, 8'h00};
        ctl = (32'(ch) << CTRL_CH_LSB) | 32'h1;
        level <= lv;
        wr(OFF_TIMING, {26'h0, tim});
        wr(OFF_CTRL0, ctl);
        repeat (40) @(posedge clk_i);
        wr(OFF_IRQ, 32'h6);
        wr(OFF_CTRL0, ctl | 32'h2);
        t_go = t_acc;
        sleep_i <= slp;
        if (frz) begin
            repeat (300) @(posedge clk_i);
            rdchk(OFF_CTRL0, ctl | 32'h2);
            sleep_i <= 1'b0;
        end
        n = 0;
        do begin
            apb(1'b0, OFF_CTRL0, 32'h0, q, e);
            n++;
        end while (q[CTRL_GO] !== 1'b0 && n < 3000);
        guard(q[CTRL_GO] === 1'b0);
        sleep_i <= 1'b0;
        chk(q, ctl);
        rdchk(OFF_IRQ, 32'h7);
        rdchk(OFF_RES_HIGH, {28'h0, ex[11:8]});
        rdchk(OFF_RES_LOW, {24'h0, ex[7:0]});
        wr(OFF_IRQ, 32'h6);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (sample_o !== 1'b1 && n < 2000);
        guard(sample_o === 1'b1);
        // Edge monitor logs the rise by NBA; let it land first
        @(posedge clk_i);
        chk(32'(chan_o), 32'(ch));
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] q;
        logic e;
        int nacq;
        int lo;
        logic [11:0] lv;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(OFF_CTRL0, 32'h0);
        rdchk(OFF_PINREF, 32'h0);
        rdchk(OFF_TIMING, 32'h0);
        rdchk(OFF_IRQ, 32'h0);
        apb(1'b0, 8'h18, 32'h0, q, e);
        chk(q, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, 8'h18, 32'hFFFF_FFFF, q, e);
        chk({31'h0, e}, 32'h1);
        // Start without enable must not stick
        wr(OFF_CTRL0, 32'h2);
        rdchk(OFF_CTRL0, 32'h0);
        for (int i = 0; i < 2; i++) begin
            q = i ? 32'h0001_0543 : 32'h0002_1ABC;
            wr(OFF_PINREF, q);
            rdchk(OFF_PINREF, q);
            chk(32'(pin_analog_o), 32'(q[12:0]));
            chk(32'({ref_neg_ext_o, ref_pos_ext_o}), q >> 16);
        end
        // Every acquisition code, clock of 8 cycles, extreme levels
        for (int i = 0; i < 8; i++) begin
            nacq = (i == 0) ? 0 : (i < 5) ? 2 * i : 4 * i - 8;
            lv = (i == 0) ? 12'hFFF : (i == 7) ? 12'h000 :
                 12'(12'h0F3 + i * 12'h1D5);
            run_conv(4'(i), {3'(i), 3'h1}, lv, 1'b0, 1'b0);
            lo = nacq ? (nacq - 1) * 8 : 0;
            rng(t_fall - t_go, lo, nacq * 8 + 4);
            rng(t_rise - t_fall, 14 * 8, 15 * 8 + 2);
        end
        wr(OFF_RES_LOW, 32'hAA);
        rdchk(OFF_RES_LOW, 32'h00);
        // Sleep stalls the system clock source, not the RC one
        // Divide by four: comparator sync needs three clocks per period
        run_conv(4'h3, 6'h04, 12'h5A6, 1'b1, 1'b1);
        run_conv(4'h9, 6'h0B, 12'h39C, 1'b1, 1'b0);
        // Reset during acquisition keeps the last result
        wr(OFF_PINREF, 32'h0003_1FFF);
        wr(OFF_CTRL0, 32'h3);
        repeat (30) @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(OFF_CTRL0, 32'h0);
        rdchk(OFF_TIMING, 32'h0);
        rdchk(OFF_PINREF, 32'h0);
        chk({31'h0, sample_o}, 32'h0);
        chk(32'(pin_analog_o), 32'h0);
        repeat (6000) @(posedge clk_i);
        rdchk(OFF_IRQ, 32'h0);
        rdchk(OFF_RES_HIGH, 32'hA);
        rdchk(OFF_RES_LOW, 32'h9C);
        finish_test();
    end
endmodule
`default_nettype wire
